// ==== hdl/lpg_pump_gain_ctrl.v ====
`timescale 1ns/1ns
`default_nettype none
`include "lpg_defines.vh"

module lpg_pump_gain_ctrl #(
  parameter integer IDLE_CYCLES = `LPG_IDLE_CYCLES
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       reg_wr,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire       clk32k_in,
  input  wire [2:0] sat_in,
  input  wire [7:0] duty_r,
  input  wire [7:0] duty_g,
  input  wire [7:0] duty_b,
  output reg  [2:0] pwm_out,
  output reg  [1:0] pump_gain,
  output reg        red_on_supply,
  output reg  [7:0] red_drive_level,
  output reg  [7:0] green_drive_level,
  output reg  [7:0] blue_drive_level
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg  [7:0] engine_enable_control;
  reg  [7:0] pump_and_pwm_config;
  wire [1:0] pump_mode_select     = pump_and_pwm_config[`LPG_CFG_MODE_HI:`LPG_CFG_MODE_LO];
  wire       pwm_fast_rate_select = pump_and_pwm_config[`LPG_CFG_FAST_BIT];
  wire       log_scale            = engine_enable_control[`LPG_ENA_LOG_BIT];
  wire       red_sup_bit          = pump_and_pwm_config[`LPG_CFG_RSUP_BIT];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      engine_enable_control <= `LPG_RST_ENABLE;
      pump_and_pwm_config   <= `LPG_RST_CONFIG;
      red_drive_level       <= `LPG_RST_LEVEL;
      green_drive_level     <= `LPG_RST_LEVEL;
      blue_drive_level      <= `LPG_RST_LEVEL;
      red_on_supply         <= 1'b0;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `LPG_ADDR_ENABLE:  engine_enable_control <= reg_wdata;
          `LPG_ADDR_RED_LVL: red_drive_level       <= reg_wdata;
          `LPG_ADDR_GRN_LVL: green_drive_level     <= reg_wdata;
          `LPG_ADDR_BLU_LVL: blue_drive_level      <= reg_wdata;
          `LPG_ADDR_CONFIG:  pump_and_pwm_config   <= reg_wdata;
          default: ;
        endcase
      end
      // Green and blue have no select: they are hard-wired to the pump.
      red_on_supply <= red_sup_bit;
    end
  end

  // The read port answers one edge after the address, whatever the strobe does.
  // Unmapped offsets read as zero so software can probe the map safely.
  reg  [7:0] next_rdata;

  always @* begin
    case (reg_addr)
      `LPG_ADDR_ENABLE:  next_rdata = engine_enable_control;
      `LPG_ADDR_RED_LVL: next_rdata = red_drive_level;
      `LPG_ADDR_GRN_LVL: next_rdata = green_drive_level;
      `LPG_ADDR_BLU_LVL: next_rdata = blue_drive_level;
      `LPG_ADDR_CONFIG:  next_rdata = pump_and_pwm_config;
      default:           next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= next_rdata;
  end

  // ----------------------------------------------------------------------
  // 32 kHz input synchroniser and PWM step tick
  // ----------------------------------------------------------------------
  // Both edges of the 32 kHz clock are used, so 256 steps fit one 256 Hz period.
  reg        ck_s1;
  reg        ck_s2;
  reg        ck_s3;
  reg        ck_acc;
  reg [9:0]  osc_div;
  reg        step;
  wire       ck_edge  = (ck_s2 == ck_s3) && (ck_s3 != ck_acc);
  wire       osc_tick = (osc_div == `LPG_FAST_TICK_LAST);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ck_s1   <= 1'b0;
      ck_s2   <= 1'b0;
      ck_s3   <= 1'b0;
      ck_acc  <= 1'b0;
      osc_div <= 10'h000;
      step    <= 1'b0;
    end else begin
      ck_s1   <= clk32k_in;
      ck_s2   <= ck_s1;
      ck_s3   <= ck_s2;
      if (ck_s2 == ck_s3)
        ck_acc <= ck_s3;
      osc_div <= osc_tick ? 10'h000 : osc_div + 10'h001;
      step    <= pwm_fast_rate_select ? osc_tick : ck_edge;
    end
  end

  // ----------------------------------------------------------------------
  // PWM generators
  // ----------------------------------------------------------------------
  // Square law over 256 codes: monotonic, roughly perceptual, cheap in gates.
  function [7:0] log_map;
    input [7:0] d;
    reg   [15:0] sq;
    begin
      sq      = d * d;
      log_map = sq[15:8];
    end
  endfunction

  reg  [7:0]  pwm_cnt;
  wire [23:0] duty_all = {duty_b, duty_g, duty_r};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      pwm_cnt <= 8'h00;
    else if (step)
      pwm_cnt <= pwm_cnt + 8'h01;
  end

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_pwm
      wire [7:0] duty = duty_all[ch*8 +: 8];
      wire [7:0] cmp  = log_scale ? log_map(duty) : duty;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          pwm_out[ch] <= 1'b0;
        else
          pwm_out[ch] <= (pwm_cnt < cmp);
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Headroom monitor synchronisers and filters
  // ----------------------------------------------------------------------
  reg [2:0] sat_filt;

  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_mon
      reg        s1;
      reg        s2;
      reg        s3;
      reg        acc;
      reg [15:0] hold;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1          <= 1'b0;
          s2          <= 1'b0;
          s3          <= 1'b0;
          acc         <= 1'b0;
          hold        <= 16'h0000;
          sat_filt[ch] <= 1'b0;
        end else begin
          s1 <= sat_in[ch];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3)
            acc <= s3;
          // A level must persist for the whole window before it counts.
          if (acc == sat_filt[ch]) begin
            hold <= 16'h0000;
          end else if (hold == `LPG_FILT_LAST) begin
            hold         <= 16'h0000;
            sat_filt[ch] <= acc;
          end else begin
            hold <= hold + 16'h0001;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Idle timer and gain selection
  // ----------------------------------------------------------------------
  // The gain is a three-state machine whose codes are the pump gain codes.
  // Off is reachable only through the mode field, never through the monitors.
  localparam [1:0] ST_OFF  = `LPG_GAIN_OFF;
  localparam [1:0] ST_1X   = `LPG_GAIN_1X;
  localparam [1:0] ST_1P5X = `LPG_GAIN_1P5X;

  reg  [22:0] idle_cnt;
  reg         idle;
  reg  [22:0] next_idle_cnt;
  reg         next_idle;
  reg  [1:0]  next_gain;
  wire        any_active = |pwm_out;
  wire        need_boost = sat_filt[1] | sat_filt[2] | (sat_filt[0] & ~red_sup_bit);

  // The counter stops at its end value, so a long dark spell cannot wrap it
  // back to zero and briefly release the bypass.
  always @* begin
    next_idle_cnt = idle_cnt;
    next_idle     = idle;
    if (any_active) begin
      next_idle_cnt = 23'h000000;
      next_idle     = 1'b0;
    end else if (idle_cnt == IDLE_CYCLES[22:0]) begin
      next_idle = 1'b1;
    end else begin
      next_idle_cnt = idle_cnt + 23'h000001;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt <= 23'h000000;
      idle     <= 1'b0;
    end else begin
      idle_cnt <= next_idle_cnt;
      idle     <= next_idle;
    end
  end

  // Idle wins over a boost request: a dark string needs no headroom.
  always @* begin
    case (pump_mode_select)
      `LPG_MODE_OFF: begin
        next_gain = ST_OFF;
      end
      `LPG_MODE_1X: begin
        next_gain = ST_1X;
      end
      `LPG_MODE_1P5X: begin
        next_gain = ST_1P5X;
      end
      `LPG_MODE_AUTO: begin
        case (pump_gain)
          ST_1P5X: begin
            if (idle || !need_boost)
              next_gain = ST_1X;
            else
              next_gain = ST_1P5X;
          end
          default: begin
            if (!idle && need_boost)
              next_gain = ST_1P5X;
            else
              next_gain = ST_1X;
          end
        endcase
      end
      default: begin
        next_gain = ST_OFF;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      pump_gain <= ST_OFF;
    else
      pump_gain <= next_gain;
  end

endmodule // lpg_pump_gain_ctrl
`default_nettype wire

// ==== hdl/lpg_defines.vh ====
`ifndef LPG_DEFINES_VH
`define LPG_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define LPG_ADDR_ENABLE   8'h00
`define LPG_ADDR_RED_LVL  8'h05
`define LPG_ADDR_GRN_LVL  8'h06
`define LPG_ADDR_BLU_LVL  8'h07
`define LPG_ADDR_CONFIG   8'h08

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LPG_ENA_LOG_BIT    7
`define LPG_CFG_FAST_BIT   6
`define LPG_CFG_MODE_HI    4
`define LPG_CFG_MODE_LO    3
`define LPG_CFG_RSUP_BIT   0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LPG_RST_ENABLE    8'h00
`define LPG_RST_LEVEL     8'hAF
`define LPG_RST_CONFIG    8'h00

// ----------------------------------------------------------------------
// Pump mode and gain encodings
// ----------------------------------------------------------------------
`define LPG_MODE_OFF      2'h0
`define LPG_MODE_1X       2'h1
`define LPG_MODE_1P5X     2'h2
`define LPG_MODE_AUTO     2'h3
`define LPG_GAIN_OFF      2'h0
`define LPG_GAIN_1X       2'h1
`define LPG_GAIN_1P5X     2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define LPG_CLK_HZ        125000000
`define LPG_CLK_PERIOD_NS 8
`define LPG_IDLE_TIME_MS  50
`define LPG_IDLE_CYCLES   ((`LPG_IDLE_TIME_MS * 1000000) / `LPG_CLK_PERIOD_NS)
`define LPG_FILT_TIME_NS  10000
`define LPG_FILT_CYCLES   ((`LPG_FILT_TIME_NS + `LPG_CLK_PERIOD_NS - 1) / `LPG_CLK_PERIOD_NS)
`define LPG_FAST_PWM_HZ   558
`define LPG_FAST_DIV      (`LPG_CLK_HZ / (`LPG_FAST_PWM_HZ * 256))
`define LPG_FAST_TICK_LAST 10'h36A
`define LPG_FILT_LAST      16'h04E1

`endif

// ==== tb/lpg_pump_gain_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module lpg_pump_gain_chk #(parameter int IDLE_CYCLES = 200) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] sat_in,
  input wire logic [2:0] pwm_out,
  input wire logic [1:0] pump_gain,
  input wire logic       red_on_supply,
  input wire logic [7:0] red_drive_level,
  input wire logic [7:0] green_drive_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] cfg_q;
  int         idle_cnt;
  wire  [1:0] mode = cfg_q[4:3];
  // The red monitor only counts while red is fed from the pump.
  wire  [2:0] mon  = sat_in & {2'b11, ~cfg_q[0]};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= 8'h00;
      idle_cnt <= 0;
    end else begin
      if (reg_wr && reg_addr == 8'h08)
        cfg_q <= reg_wdata;
      if (pwm_out != 3'h0)
        idle_cnt <= 0;
      else if (idle_cnt < IDLE_CYCLES + 64)
        idle_cnt <= idle_cnt + 1;
    end
  end
  property p_forced; mode != 2'h3 && $stable(mode) |-> pump_gain == mode; endproperty
  a_forced: assert property (p_forced) else $error("forced gain wrong");
  property p_auto; mode == 2'h3 && $stable(mode) |-> pump_gain inside {2'h1, 2'h2}; endproperty
  a_auto: assert property (p_auto) else $error("auto gain off");
  property p_boost; (mode == 2'h3) [*2] ##0 (pump_gain == 2'h2 && $past(pump_gain) != 2'h2)
    |-> $past(mon, 8) != 3'h0; endproperty
  a_boost: assert property (p_boost) else $error("boost without filtered cause");
  property p_idle; mode == 2'h3 && $stable(mode) && idle_cnt > IDLE_CYCLES + 8 |-> pump_gain == 2'h1; endproperty
  a_idle: assert property (p_idle) else $error("idle not bypass");
  property p_redsup; $stable(cfg_q[0]) |-> red_on_supply == cfg_q[0]; endproperty
  a_redsup: assert property (p_redsup) else $error("red supply wrong");
  property p_lvl_r; reg_wr && reg_addr == 8'h05 |=> red_drive_level == $past(reg_wdata); endproperty
  a_lvl_r: assert property (p_lvl_r) else $error("red level write");
  property p_lvl_g; reg_wr && reg_addr == 8'h06 |=> green_drive_level == $past(reg_wdata); endproperty
  a_lvl_g: assert property (p_lvl_g) else $error("green level write");
  property p_rd; !reg_wr && reg_addr == 8'h06 |=> reg_rdata == $past(green_drive_level); endproperty
  a_rd: assert property (p_rd) else $error("level read");
  property p_unm; reg_addr inside {8'h01, 8'h02, 8'h03, 8'h04} |=> reg_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
endmodule // lpg_pump_gain_chk
`default_nettype wire

// ==== tb/lpg_analog_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module lpg_analog_model (
  input  wire logic [1:0] pump_gain,
  input  wire logic [2:0] lack,
  output logic            clk32k,
  output logic [2:0]      sat_in
);
  // With the pump off no driver has headroom, so every monitor reports saturation.
  assign sat_in = (pump_gain == 2'h0) ? 3'h7 : lack;
  initial begin
    clk32k = 1'b0;
    forever #15625 clk32k = ~clk32k;
  end
endmodule // lpg_analog_model
`default_nettype wire

// ==== tb/led_drive_pump_gain_control_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module led_drive_pump_gain_control_test;
  logic       clk = 0, rst_n = 0, reg_wr = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, duty = 8'h00;
  logic [2:0] lack = 3'h0;
  wire  [7:0] reg_rdata, lvl_r, lvl_g, lvl_b;
  wire  [2:0] sat_in, pwm_out;
  wire  [1:0] pump_gain;
  wire        clk32k, red_sup;
  int         bad_count = 0, comparisons = 0;
  lpg_pump_gain_ctrl #(.IDLE_CYCLES(200)) dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .clk32k_in(clk32k),
    .sat_in(sat_in), .duty_r(duty), .duty_g(duty), .duty_b(duty), .pwm_out(pwm_out),
    .pump_gain(pump_gain), .red_on_supply(red_sup), .red_drive_level(lvl_r),
    .green_drive_level(lvl_g), .blue_drive_level(lvl_b));
  lpg_analog_model model (.pump_gain(pump_gain), .lack(lack), .clk32k(clk32k), .sat_in(sat_in));
  initial forever #4 clk = ~clk;
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    #1 chk("rdata", reg_rdata, exp);
  endtask
  task gain(input int n, input logic [1:0] exp);
    repeat (n) @(posedge clk);
    #1 chk("gain", {6'h00, pump_gain}, {6'h00, exp});
  endtask
  task complete_run;
    if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h05, 8'hAF);
    rd(8'h08, 8'h00);
    rd(8'h03, 8'h00);
    wr(8'h06, 8'h00);
    wr(8'h07, 8'hFF);
    wr(8'h02, 8'h55);
    rd(8'h06, 8'h00);
    rd(8'h02, 8'h00);
    chk("blue", lvl_b, 8'hFF);
    wr(8'h00, 8'h80);
    rd(8'h00, 8'h80);
    @(posedge clk);
    lack <= 3'h7;
    for (int m = 0; m < 3; m++) begin
      wr(8'h08, 8'(m << 3));
      gain(3, 2'(m));
    end
    @(posedge clk);
    duty <= 8'hFF;
    lack <= 3'h1;
    wr(8'h08, 8'h58);
    gain(1400, 2'h2);
    chk("pwm", {5'h00, pwm_out}, 8'h07);
    @(posedge clk);
    lack <= 3'h0;
    repeat (100) @(posedge clk);
    lack <= 3'h1;
    gain(1400, 2'h2);
    @(posedge clk);
    lack <= 3'h0;
    gain(1400, 2'h1);
    wr(8'h08, 8'h59);
    lack <= 3'h1;
    gain(1400, 2'h1);
    chk("red_sup", {7'h00, red_sup}, 8'h01);
    @(posedge clk);
    lack <= 3'h2;
    gain(1400, 2'h2);
    @(posedge clk);
    duty <= 8'h00;
    gain(400, 2'h1);
    chk("pwm", {5'h00, pwm_out}, 8'h00);
    complete_run();
  end
  // Bound well above the expected run so only a hang trips it.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule // led_drive_pump_gain_control_test
bind lpg_pump_gain_ctrl lpg_pump_gain_chk #(.IDLE_CYCLES(IDLE_CYCLES)) chk (.clk, .rst_n, .reg_wr,
  .reg_addr, .reg_wdata, .reg_rdata, .sat_in, .pwm_out, .pump_gain, .red_on_supply,
  .red_drive_level, .green_drive_level);
`default_nettype wire
